// File: logic/flsi_top.sv
// Operation
// - LIU off and NRZ: data on rail A at line clock rise, rail B idle.
// - LIU off, dual-rail: rails A and B complementary, updated at line clock rise.
// - Receive positive input carries data; negative input carries its complement.
// - Gapped link clock at 4 to 20 kHz; partner captures on rising edges.
// - Received data leaves as serial link stream, changing on recovered clock rise.
// - Low on transmit multiframe input sets the transmit multiframe boundary.
// - Transmit multiframe input high: device generates multiframe alignment itself.
// - Receive multiframe marker pulses so next frame out is frame zero.
// - E1 receive marker follows CRC multiframe if source bit set, else signaling.
// - Sync select high: system clock, frame pulse are inputs; low: outputs.
// - Device drives 4.096 MHz system clock whenever sync select is low, in any mode.
// - Recovered clock is output and captures received line data.
// - LIU off: same clock output at line rate launches transmit rail data.
// - Frame pulse delimits 32-channel frame; device drives it while sync select is low.
// - Receive frame pulse at 8 kHz, low one recovered clock period.
`timescale 1ns/1ps
`include "flsi_consts.svh"
module flsi_top
    import flsi_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        rx_line_pos,
    input  wire logic        rx_line_neg,
    input  wire logic        tx_multiframe_mark,
    input  wire logic        bus_line_sync_select,
    input  wire logic        system_clk_4m_i,
    output logic             system_clk_4m_o,
    output logic             system_clk_4m_oe_n,
    input  wire logic        frame_sync_pulse_i,
    output logic             frame_sync_pulse_o,
    output logic             frame_sync_pulse_oe_n,
    output logic             tx_rail_a,
    output logic             tx_rail_b,
    output logic             recovered_line_clk,
    output logic             rx_link_gapped_clk,
    output logic             rx_link_serial,
    output logic             rx_multiframe_mark,
    output logic             rx_frame_pulse
);
    //------------------------------------------------------------------
    // Pin synchronisers
    //------------------------------------------------------------------
    logic [5:0] pin_raw;
    logic [5:0] pin_s1_ff;
    logic [5:0] pin_s2_ff;
    assign pin_raw = {frame_sync_pulse_i, system_clk_4m_i, bus_line_sync_select,
                      tx_multiframe_mark, rx_line_neg, rx_line_pos};
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_sync
            // Two stages per asynchronous pin
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pin_s1_ff[gi] <= 1'b1;
                    pin_s2_ff[gi] <= 1'b1;
                end else begin
                    pin_s1_ff[gi] <= pin_raw[gi];
                    pin_s2_ff[gi] <= pin_s1_ff[gi];
                end
            end
        end
    endgenerate
    logic rx_pos_s, rx_neg_s, tx_multiframe_mark_s, bls_s, ext_c4_s, ext_f0_s;
    assign {ext_f0_s, ext_c4_s, bls_s, tx_multiframe_mark_s, rx_neg_s, rx_pos_s} = pin_s2_ff;

    //------------------------------------------------------------------
    // Control register and mode
    //------------------------------------------------------------------
    logic [7:0]     ctrl_ff;
    logic           t1_mode, nrz, liu_en, rx_multiframe_source;
    logic [2:0]     link_rate;
    flsi_clk_mode_e clk_mode;
    assign t1_mode   = ctrl_ff[`FLSI_CTRL_T1];
    assign nrz       = ctrl_ff[`FLSI_CTRL_NRZ];
    assign liu_en    = ctrl_ff[`FLSI_CTRL_LIU];
    assign rx_multiframe_source     = ctrl_ff[`FLSI_CTRL_RX_MULTIFRAME_SOURCE];
    assign link_rate = ctrl_ff[`FLSI_CTRL_RATE_HI:`FLSI_CTRL_RATE_LO];
    // Bus-sync needs both selects; the pin alone sets pin direction
    assign clk_mode = !ctrl_ff[`FLSI_CTRL_SFR] ? FLSI_FREERUN :
                      (bls_s ? FLSI_BUSSYNC : FLSI_LINESYNC);

    //------------------------------------------------------------------
    // Clock synthesis: phase accumulators on aclk, edges as enables
    //------------------------------------------------------------------
    localparam logic [63:0] T1_STEP64  = (64'(`FLSI_T1_HZ) << 32) / 64'(`FLSI_ACLK_HZ);
    localparam logic [63:0] E1_STEP64  = (64'(`FLSI_E1_HZ) << 32) / 64'(`FLSI_ACLK_HZ);
    localparam logic [63:0] SYS_STEP64 = (64'(`FLSI_SYS_HZ) << 32) / 64'(`FLSI_ACLK_HZ);
    logic [31:0] line_acc_ff, sys_acc_ff, line_step;
    logic        line_msb_ff, sys_msb_ff, line_tick, sys_tick, sys_resync;
    assign line_step = t1_mode ? T1_STEP64[31:0] : E1_STEP64[31:0];
    assign line_tick = line_acc_ff[31] && !line_msb_ff;
    assign sys_tick  = sys_acc_ff[31] && !sys_msb_ff;

    // Line accumulator: one rise per line bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_acc_ff <= 32'h0;
            line_msb_ff <= 1'b0;
        end else begin
            line_acc_ff <= line_acc_ff + line_step;
            line_msb_ff <= line_acc_ff[31];
        end
    end

    // System clock accumulator; line-sync re-phases it each line frame
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_acc_ff <= 32'h0;
            sys_msb_ff <= 1'b0;
        end else begin
            sys_acc_ff <= sys_resync ? 32'h0 : sys_acc_ff + SYS_STEP64[31:0];
            sys_msb_ff <= sys_acc_ff[31];
        end
    end

    //------------------------------------------------------------------
    // Transmit path
    //------------------------------------------------------------------
    logic        txb_in_valid, txb_in_ready, txb_out_valid, txb_pop;
    logic [31:0] txb_out_data, tx_shift_ff;
    logic [4:0]  tx_bitcnt_ff, tx_frame_ff;
    logic [5:0]  tx_left_ff;
    logic        tx_bit;
    logic [8:0]  frm_last;
    logic [4:0]  tx_mf_last;
    assign frm_last   = (t1_mode ? `FLSI_T1_BITS : `FLSI_E1_BITS) - 9'd1;
    assign tx_mf_last = (t1_mode ? `FLSI_T1_MF : `FLSI_E1_CAS_MF) - 5'd1;
    assign txb_pop    = line_tick && (tx_left_ff == 6'd0);
    assign tx_bit     = (tx_left_ff == 6'd0) ? (txb_out_valid ? txb_out_data[0] : 1'b1)
                                             : tx_shift_ff[0];

    flsi_skid_buf #(.W(32)) u_txbuf (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (txb_in_valid),
        .in_ready  (txb_in_ready),
        .in_data   (s_axi_wdata),
        .out_valid (txb_out_valid),
        .out_ready (txb_pop),
        .out_data  (txb_out_data)
    );

    // Word serialiser, LSB first; idle ones when software runs dry
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_shift_ff <= 32'h0;
            tx_left_ff  <= 6'd0;
        end else if (line_tick) begin
            if (tx_left_ff == 6'd0) begin
                tx_shift_ff <= {1'b1, txb_out_data[31:1]};
                tx_left_ff  <= txb_out_valid ? 6'd31 : 6'd0;
            end else begin
                tx_shift_ff <= {1'b1, tx_shift_ff[31:1]};
                tx_left_ff  <= tx_left_ff - 6'd1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_rail_a <= 1'b0;
            tx_rail_b <= 1'b0;
        end else if (line_tick) begin
            tx_rail_a <= !liu_en && tx_bit;
            tx_rail_b <= !liu_en && !nrz && !tx_bit;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_bitcnt_ff <= 5'd0;
            tx_frame_ff  <= 5'd0;
        end else if (!tx_multiframe_mark_s) begin
            tx_bitcnt_ff <= 5'd0;
            tx_frame_ff  <= 5'd0;
        end else if (line_tick) begin
            tx_bitcnt_ff <= tx_bitcnt_ff + 5'd1;
            if (tx_bitcnt_ff == 5'd31) begin
                tx_frame_ff <= (tx_frame_ff == tx_mf_last) ? 5'd0 : tx_frame_ff + 5'd1;
            end
        end
    end

    //------------------------------------------------------------------
    // Receive path
    //------------------------------------------------------------------
    logic [8:0]  rx_bit_ff;
    logic [4:0]  rx_frame_ff, rx_mf_last;
    logic [31:0] rx_word_ff;
    logic        rx_data, split_bad;
    logic        link_gate;
    logic [3:0]  link_bits;
    assign rx_data    = rx_pos_s;
    assign split_bad  = !nrz && (rx_pos_s == rx_neg_s);
    assign rx_mf_last = (t1_mode ? `FLSI_T1_MF : (rx_multiframe_source ? `FLSI_E1_CRC_MF
                                                        : `FLSI_E1_CAS_MF)) - 5'd1;
    assign link_bits  = (link_rate > 3'd4) ? 4'd1 : 4'({1'b0, link_rate}) + 4'd1;
    // Two-frame window: N bits pass per window gives N x 4 kHz
    assign link_gate  = rx_frame_ff[0] == 1'b0 && rx_bit_ff < 9'(link_bits);
    assign sys_resync = (clk_mode == FLSI_LINESYNC) && line_tick && (rx_bit_ff == frm_last);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_bit_ff   <= 9'd0;
            rx_frame_ff <= 5'd0;
            rx_word_ff  <= 32'h0;
        end else if (line_tick) begin
            rx_word_ff <= {rx_data, rx_word_ff[31:1]};
            rx_bit_ff  <= (rx_bit_ff == frm_last) ? 9'd0 : rx_bit_ff + 9'd1;
            if (rx_bit_ff == frm_last) begin
                rx_frame_ff <= (rx_frame_ff >= rx_mf_last) ? 5'd0 : rx_frame_ff + 5'd1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_link_serial     <= 1'b1;
            rx_multiframe_mark <= 1'b1;
            rx_frame_pulse     <= 1'b1;
        end else if (line_tick) begin
            rx_link_serial     <= rx_data;
            rx_multiframe_mark <= !(rx_bit_ff == frm_last && rx_frame_ff >= rx_mf_last);
            rx_frame_pulse     <= !(rx_bit_ff == frm_last);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            recovered_line_clk <= 1'b0;
            rx_link_gapped_clk <= 1'b0;
        end else begin
            recovered_line_clk <= line_acc_ff[31];
            rx_link_gapped_clk <= !line_acc_ff[31] && link_gate;
        end
    end

    //------------------------------------------------------------------
    // System clock and frame pulse pins
    //------------------------------------------------------------------
    logic [8:0] sys_cnt_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_cnt_ff <= 9'd0;
        end else if (sys_resync) begin
            sys_cnt_ff <= 9'd0;
        end else if (sys_tick) begin
            sys_cnt_ff <= sys_cnt_ff + 9'd1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            system_clk_4m_o       <= 1'b1;
            system_clk_4m_oe_n    <= 1'b1;
            frame_sync_pulse_o    <= 1'b1;
            frame_sync_pulse_oe_n <= 1'b1;
        end else begin
            system_clk_4m_o       <= !sys_acc_ff[31];
            system_clk_4m_oe_n    <= bls_s;
            frame_sync_pulse_o    <= !(sys_cnt_ff == `FLSI_SYS_PER_FRM);
            frame_sync_pulse_oe_n <= bls_s;
        end
    end

    //------------------------------------------------------------------
    // AXI4-Lite slave
    //------------------------------------------------------------------
    logic       aw_full_ff, w_full_ff, wr_fire, is_txdata;
    logic [3:0] aw_addr_ff, ar_addr;
    logic [31:0] w_data_ff, status;
    logic [3:0]  w_strb_ff;
    assign is_txdata    = aw_addr_ff == `FLSI_REG_TXDATA;
    // TXDATA waits for buffer room: back-pressure reaches the master
    assign wr_fire      = aw_full_ff && w_full_ff && !s_axi_bvalid
                          && (!is_txdata || txb_in_ready);
    assign txb_in_valid = wr_fire && is_txdata;
    assign ar_addr      = s_axi_araddr;
    assign status = {13'h0, split_bad, rx_frame_ff, 3'h0, tx_frame_ff,
                     ext_f0_s, ext_c4_s, bls_s, txb_out_valid, !txb_in_ready};
    assign s_axi_awready = !aw_full_ff;
    assign s_axi_wready  = !w_full_ff;
    assign s_axi_arready = !s_axi_rvalid;

    // Address and data captured in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_ff <= 1'b0;
            w_full_ff  <= 1'b0;
            aw_addr_ff <= 4'h0;
            w_data_ff  <= 32'h0;
            w_strb_ff  <= 4'h0;
        end else begin
            if (s_axi_awvalid && !aw_full_ff) begin
                aw_full_ff <= 1'b1;
                aw_addr_ff <= {s_axi_awaddr[3:2], 2'b00};
            end else if (wr_fire) begin
                aw_full_ff <= 1'b0;
            end
            if (s_axi_wvalid && !w_full_ff) begin
                w_full_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_full_ff <= 1'b0;
            end
        end
    end

    // Register write and write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff      <= `FLSI_CTRL_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= FLSI_OKAY;
        end else begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_ff == `FLSI_REG_CTRL || is_txdata) ? FLSI_OKAY
                                                                            : FLSI_SLVERR;
                if (aw_addr_ff == `FLSI_REG_CTRL && w_strb_ff[0]) begin
                    ctrl_ff <= w_data_ff[7:0];
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel, one cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= FLSI_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= FLSI_OKAY;
            unique case ({ar_addr[3:2], 2'b00})
                `FLSI_REG_CTRL:   s_axi_rdata <= {24'h0, ctrl_ff};
                `FLSI_REG_TXDATA: s_axi_rdata <= 32'h0;
                `FLSI_REG_STATUS: s_axi_rdata <= status;
                `FLSI_REG_RXDATA: s_axi_rdata <= rx_word_ff;
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= FLSI_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_word_load;
        line_tick && tx_left_ff == 6'd0 && txb_out_valid;
    endsequence
    // Line ticks lie far apart, so the full count must hold for two cycles
    sequence s_word_shift;
        (tx_left_ff == 6'd31) ##1 (tx_left_ff == 6'd31);
    endsequence

    a_nrz_rail_b: assert property (line_tick && nrz |=> !tx_rail_b)
        else $error("rail B active in NRZ mode");
    a_dual_pair: assert property (line_tick && !nrz && !liu_en |=> tx_rail_a != tx_rail_b)
        else $error("dual rails not complementary");
    a_rail_launch: assert property (!line_tick |=> $stable(tx_rail_a))
        else $error("rail A moved off line clock rise");
    a_word_start: assert property (s_word_load |=> s_word_shift)
        else $error("word load did not start 32-bit shift");
    a_link_stable: assert property (!line_tick |=> $stable(rx_link_serial))
        else $error("link stream moved off recovered rise");
    a_gap_window: assert property ($rose(rx_link_gapped_clk) |-> $past(link_gate))
        else $error("gapped clock outside window");
    a_tx_multiframe_mark_set: assert property (!tx_multiframe_mark_s |=> tx_frame_ff == 5'd0 && tx_bitcnt_ff == 5'd0)
        else $error("tx multiframe not set by marker");
    a_tx_multiframe_mark_free: assert property (tx_multiframe_mark_s && line_tick && tx_bitcnt_ff == 5'd31 &&
                                  tx_frame_ff != tx_mf_last && $stable(tx_multiframe_mark_s)
                                  |=> tx_frame_ff == $past(tx_frame_ff) + 5'd1)
        else $error("internal tx multiframe did not advance");
    a_rx_multiframe_mark_place: assert property ($fell(rx_multiframe_mark) |->
                                   $past(rx_bit_ff) == $past(frm_last))
        else $error("rx marker not at frame end");
    a_rx_frame_pulse_low: assert property ($fell(rx_frame_pulse) |=> !rx_frame_pulse [*8])
        else $error("rx frame pulse too short");
    a_pin_dir: assert property (bls_s ##1 bls_s |-> system_clk_4m_oe_n
                                && frame_sync_pulse_oe_n)
        else $error("pins driven while sync select high");
    a_sys_drive: assert property (!bls_s ##1 !bls_s |-> !system_clk_4m_oe_n)
        else $error("system clock not driven");
endmodule

// File: logic/flsi_consts.svh
`ifndef FLSI_CONSTS_SVH
`define FLSI_CONSTS_SVH

// Register byte offsets
`define FLSI_REG_CTRL      4'h0
`define FLSI_REG_TXDATA    4'h4
`define FLSI_REG_STATUS    4'h8
`define FLSI_REG_RXDATA    4'hC

// Control register fields
`define FLSI_CTRL_T1       0
`define FLSI_CTRL_NRZ      1
`define FLSI_CTRL_LIU      2
`define FLSI_CTRL_SFR      3
`define FLSI_CTRL_RX_MULTIFRAME_SOURCE    4
`define FLSI_CTRL_RATE_LO  5
`define FLSI_CTRL_RATE_HI  7
`define FLSI_CTRL_RESET    8'h02

// Clock rates in Hz
`define FLSI_ACLK_HZ       100000000
`define FLSI_T1_HZ         1544000
`define FLSI_E1_HZ         2048000
`define FLSI_SYS_HZ        4096000

// Frame geometry
`define FLSI_T1_BITS       9'd193
`define FLSI_E1_BITS       9'd256
`define FLSI_T1_MF         5'd24
`define FLSI_E1_CAS_MF     5'd16
`define FLSI_E1_CRC_MF     5'd16
`define FLSI_SYS_PER_FRM   9'd511

`endif

// File: logic/flsi_pkg.sv
package flsi_pkg;
    typedef enum logic [1:0] {
        FLSI_FREERUN,
        FLSI_LINESYNC,
        FLSI_BUSSYNC
    } flsi_clk_mode_e;

    typedef logic [1:0] flsi_resp_t;
    localparam flsi_resp_t FLSI_OKAY   = 2'h0;
    localparam flsi_resp_t FLSI_SLVERR = 2'h2;
endpackage

// File: logic/flsi_skid_buf.sv
`timescale 1ns/1ps
module flsi_skid_buf
    import flsi_pkg::*;
#(
    parameter int W = 32
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic [W-1:0] slot_ff [2];
    logic [1:0]   count_ff;
    logic         rd_ptr_ff;
    logic         wr_ptr_ff;
    logic         push;
    logic         pop;

    // Two entries, so a stalled drain never drops a word
    assign in_ready  = (count_ff != 2'd2);
    assign out_valid = (count_ff != 2'd0);
    assign out_data  = slot_ff[rd_ptr_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage
    always_ff @(posedge aclk) begin
        if (push) begin
            slot_ff[wr_ptr_ff] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_ff  <= 2'd0;
            rd_ptr_ff <= 1'b0;
            wr_ptr_ff <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop) begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 2'd1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 2'd1;
            end
        end
    end
endmodule

// File: bench/flsi_line_partner.sv
`timescale 1ns/1ps
// External line receiver: split-phase data timed by the recovered clock
module flsi_line_partner (
    input  wire logic recovered_line_clk,
    output logic      rx_line_pos,
    output logic      rx_line_neg,
    output logic      system_clk_4m_i
);
    // bus-sync clock: a pulse on each recovered edge keeps it locked
    initial system_clk_4m_i = 1'h0;
    always @(recovered_line_clk) begin
        system_clk_4m_i <= 1'h1;
        #122 system_clk_4m_i <= 1'h0;
    end
    assign rx_line_neg = ~rx_line_pos;
    // data moves mid-bit, away from the capture point; alternating bits
    // make any slip or stuck capture visible in the received word
    initial rx_line_pos = 1'h0;
    always @(negedge recovered_line_clk) rx_line_pos <= ~rx_line_pos;
endmodule

// File: bench/test_framer_line_sync_interface.sv
`timescale 1ns/1ps
module test_framer_line_sync_interface import flsi_pkg::*; ;
    logic        aclk = 1'h0, aresetn = 1'h0, tx_multiframe_mark = 1'h1;
    logic        bus_line_sync_select = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_arready, s_axi_rvalid;
    logic [3:0]  s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        rx_line_pos, rx_line_neg, system_clk_4m_o, system_clk_4m_oe_n, tx_rail_a;
    logic        frame_sync_pulse_oe_n, tx_rail_b, recovered_line_clk, rx_frame_pulse;
    logic        frame_sync_pulse_o, rx_link_gapped_clk, rx_link_serial, system_clk_4m_i;
    int          fail_count = 0, checks_done = 0, cyc = 0;

    flsi_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_line_pos, .rx_line_neg,
        .tx_multiframe_mark, .bus_line_sync_select, .system_clk_4m_i, .system_clk_4m_o,
        .system_clk_4m_oe_n, .frame_sync_pulse_i(1'h1), .frame_sync_pulse_o,
        .frame_sync_pulse_oe_n, .tx_rail_a, .tx_rail_b, .recovered_line_clk,
        .rx_link_gapped_clk, .rx_link_serial, .rx_multiframe_mark(), .rx_frame_pulse);
    flsi_line_partner partner (.recovered_line_clk, .rx_line_pos, .rx_line_neg,
        .system_clk_4m_i);

    always #5 aclk = ~aclk;
    // Hang guard, only a little above the full run of all tests
    always @(posedge aclk) if (++cyc == 90000) begin fail_count++; final_report; end

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Range compare; an unknown never counts as inside
    task automatic rng(input string nm, input logic [31:0] lo, hi, got);
        checks_done++;
        if ((got >= lo && got <= hi) !== 1'h1) begin
            fail_count++;
            $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask
    // Write: address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr <= a; s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1; s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        r = s_axi_bresp; s_axi_bready <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
        s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata; s_axi_rready <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic rises(ref logic s, input int n, output int r);
        logic p;
        r = 0; p = s;
        repeat (n) begin @(posedge aclk); r += (s && !p); p = s; end
    endtask

    task automatic t_regs;
        logic [31:0] d;
        logic [1:0]  b;
        axi_rd(4'h0, d); rng("ctrl reset", 32'h2, 32'h2, d);
        axi_rd(4'h4, d); rng("txdata read", 0, 0, d);
        axi_wr(4'h8, 32'h2, b); rng("unmapped resp", FLSI_SLVERR, FLSI_SLVERR, {30'h0, b});
    endtask
    // Single rail: B idle, A moves only just after a line clock rise
    task automatic t_single_rail;
        logic [1:0] b;
        logic       pa, pc;
        int         since, moves;
        since = 9; moves = 0; pa = tx_rail_a; pc = recovered_line_clk;
        axi_wr(4'h4, 32'h0F0F0F0F, b);
        repeat (3000) begin
            @(posedge aclk);
            since = (recovered_line_clk && !pc) ? 0 : since + 1;
            if (tx_rail_a !== pa) begin moves++; rng("rail a launch", 0, 3, since); end
            rng("rail b idle", 0, 0, {31'h0, tx_rail_b});
            pa = tx_rail_a; pc = recovered_line_clk;
        end
        rng("rail a moves", 8, 3000, moves);
    endtask
    task automatic t_rx_data;
        logic [31:0] d;
        int          r;
        axi_rd(4'hC, d);
        rng("rx word", 1, 1, {31'h0, d === 32'hAAAAAAAA || d === 32'h55555555});
        rises(rx_link_serial, 1000, r); rng("link serial", 9, 11, r);
    endtask
    task automatic t_frame_pulse;
        realtime t0, t1, t2;
        @(negedge rx_frame_pulse); t0 = $realtime;
        @(posedge rx_frame_pulse); t1 = $realtime;
        @(negedge rx_frame_pulse); t2 = $realtime;
        rng("frame period", 12490, 12510, int'((t2 - t0) / 10.0));
        rng("frame low", 48, 50, int'((t1 - t0) / 10.0));
    endtask
    task automatic t_tx_mark;
        logic [31:0] d;
        int          r;
        tx_multiframe_mark <= 1'h0;
        repeat (300) @(posedge aclk);
        axi_rd(4'h8, d); rng("tx frame held", 0, 0, {27'h0, d[9:5]});
        tx_multiframe_mark <= 1'h1;
        rises(frame_sync_pulse_o, 12600, r); rng("frame sync", 1, 2, r);
        axi_rd(4'h8, d); rng("tx frame free", 1, 31, {27'h0, d[9:5]});
    endtask
    // Fastest link rate: five gapped clock rises every second frame
    task automatic t_link_clock;
        logic [1:0] b;
        int         r;
        axi_wr(4'h0, 32'h82, b);
        rises(rx_link_gapped_clk, 25100, r); rng("link clock", 5, 10, r);
    endtask
    task automatic t_line_rate(input logic [31:0] ctrl, input int lo, hi);
        logic [1:0] b;
        int         r;
        axi_wr(4'h0, ctrl, b);
        rises(recovered_line_clk, 10000, r); rng("line clock", lo, hi, r);
        repeat (60) @(posedge aclk);
        repeat (500) @(posedge aclk) rng("dual rail", 1, 1, {31'h0, tx_rail_a ^ tx_rail_b});
    endtask
    task automatic t_sync_dir;
        int r;
        for (int s = 1; s >= 0; s--) begin
            bus_line_sync_select <= s[0];
            repeat (8) @(posedge aclk);
            rng("clk pin dir", s, s, {31'h0, system_clk_4m_oe_n});
            rng("frame pin dir", s, s, {31'h0, frame_sync_pulse_oe_n});
        end
        rises(system_clk_4m_o, 1000, r); rng("system clock", 40, 42, r);
    endtask

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_regs;
        t_single_rail;
        t_rx_data;
        t_frame_pulse;
        t_tx_mark;
        t_link_clock;
        t_line_rate(32'h9, 153, 156);
        t_line_rate(32'h8, 203, 206);
        t_sync_dir;
        final_report;
    end
endmodule
